// ### bench/sosc_asserts.sv
// Link-level checks between the two ends
module sosc_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Driver on after select fall and released once deselect is seen; clock framing and bit hold
  oe_off_a: assert property (cs_n [*6] |-> !miso_oe)
    else $error("serial driver on while deselected");
  oe_on_a: assert property ($fell(cs_n) |-> ##3 miso_oe)
    else $error("serial driver not enabled");
  lead_low_a: assert property ($fell(cs_n) |-> !sclk [*7])
    else $error("clock not low around select fall");
  lag_low_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
    else $error("clock not low at select rise");
  clk_width_a: assert property ($rose(sclk) |-> sclk [*7] ##1 !sclk)
    else $error("clock high phase wrong");
  clk_frame_a: assert property ($rose(sclk) |-> !cs_n)
    else $error("clock pulse outside frame");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("command bit moved while clock high");
  miso_hold_a: assert property ($rose(sclk) |=> $stable(miso_o) [*2])
    else $error("status bit moved too early");
  // Main scenarios reached
  c_open: cover property ($fell(cs_n));
  c_close: cover property ($rose(cs_n));
  c_bit: cover property ($rose(sclk) && miso_oe);
endmodule : sosc_asserts

// ### bench/tb_serial_octal_switch_control.sv
// Host end drives device end across one link
module tb_serial_octal_switch_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 0;        // System clock
  logic       reset_n = 0;     // Async reset
  logic       clear_n = 1;     // Clear pin level
  logic       start = 0;       // Frame request
  logic [7:0] cmd = 8'h00;     // Command word
  logic [7:0] drain = 8'hFF;   // Drain levels
  logic [7:0] out_on;          // Switch states
  logic [7:0] status;          // Returned word
  logic       busy;            // Host busy
  logic       done;            // Frame finished
  int         num_errors = 0;  // Mismatches
  int         n_checks = 0;    // Comparisons
  int         cyc = 0;         // Cycle count
  sosc_if lnk ();
  sosc_dev u_sosc_dev (.mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .link(lnk), .clear_n(clear_n), .drain_status(drain),
    .out_on(out_on));
  sosc_host u_sosc_host (.mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .link(lnk), .start(start), .cmd(cmd), .busy(busy), .done(done),
    .status(status));
  sosc_asserts u_sosc_asserts (.mclk(mclk), .reset_n(reset_n),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
    .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe));
  // Free-running clock
  always #5 mclk = ~mclk;
  // Hang guard, far above ~4800 cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Zero in a command bit means ON
  function automatic logic [7:0] on_of(input logic [7:0] c);
    return ~c;
  endfunction : on_of
  // One frame; drain held steady so status is fixed
  task automatic frame(input logic [7:0] c, input logic [7:0] d);
    int n;
    drain = d;
    cmd = c;
    start = 1;
    @(posedge mclk);
    #1 start = 0;
    check({6'h00, lnk.cs_n, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 400) check(8'h01, 8'h00);
    check(status, d);
    check({6'h00, lnk.cs_n, busy}, 8'h02);
    repeat (5) @(posedge mclk);
    #1 check(out_on, on_of(c));
    $display("frame cmd=%h drain=%h done", c, d);
  endtask : frame
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    void'($urandom(32'h0911));
    repeat (3) @(posedge mclk);
    #1 reset_n = 1;
    repeat (4) @(posedge mclk);
    #1 check(out_on, 8'h00);
    check({7'h00, lnk.miso_oe}, 8'h00);
    $display("reset test done");
    frame(8'h00, 8'hFF);
    frame(8'hFF, 8'h00);
    frame(8'hA5, 8'h5A);
    frame(8'h7E, 8'h81);
    repeat (30) frame(8'($urandom), 8'($urandom));
    frame(8'h00, 8'h5A);
    clear_n = 0;
    repeat (8) @(posedge mclk);
    #1 check(out_on, 8'h00);
    clear_n = 1;
    $display("clear test done");
    frame(8'h3C, 8'hC3);
    wrap_up();
  end
endmodule : tb_serial_octal_switch_control

// ### rtl/sosc_defines.svh
// Functional notes
// - Eight outputs from one eight-bit command
// - Command zero means ON, one OFF
// - Each transfer returns drain status per output
// - Daisy chain: serial out feeds next in
// - Master may give each device own select
// - One bit each way per clock
// - Only one master drives clock at once
// - Shift and drive only while select low
// - Select rise latches register to outputs
// - Select fall loads drain status
// - Serial driver enabled while select low
// - Master lowers select only with clock low
// - Sample input falling, change output rising
// - Eight bits, MSB first, output 7 first
// - Status one when OFF, zero when ON
// - Clear empties register, forces outputs OFF
`ifndef SOSC_DEFINES_SVH
`define SOSC_DEFINES_SVH
`define SOSC_WIDTH      8
`define SOSC_CNT_W      4
`define SOSC_ALL_OFF    8'hFF
`define SOSC_ZERO8      8'h00
`define SOSC_MSB        7
`define SOSC_DIV_HALF   8'h06
`define SOSC_HALF_W     8
`define SOSC_BITS       4'h8
`define SOSC_ONE4       4'h1
`define SOSC_ZERO4      4'h0
`endif

// ### rtl/sosc_dev.sv
`include "sosc_defines.svh"
// Device end: eight-output switch serial logic
//
// A frame runs from the fall of select to its rise. At the
// fall the drain levels enter the shift register and the
// serial driver turns on with the top bit. Each fall of the
// link clock takes one command bit in at the bottom; each
// rise shows the new top bit. At the rise of select the
// register is copied to the command latch, and the switch
// outputs follow on the same system clock.
//
// Limitation: a frame of fewer than eight clocks puts drain
// status bits into the latch; more than eight pass the surplus on
// through the serial output, as a chain of devices needs.
// Clear is a level: while it is low no command sticks.
module sosc_dev (
  // Clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   ce,
  // Link
  sosc_if.dev                         link,
  // Clear input, active low, from pin
  input  wire logic                   clear_n,
  // Drain levels of the outputs
  input  wire logic [`SOSC_WIDTH-1:0] drain_status,
  // Output switch states, 1 = ON
  output logic [`SOSC_WIDTH-1:0]      out_on
);

  // Data path: pin, two-flop synchroniser, edge decode, state.
  // A link event acts here three system clocks after its pin
  // moved: two for the synchroniser, one for the edge decode.
  // Each phase of the link clock must therefore last at least
  // three system clocks, or two edges would merge into none.
  // Trade-off: sampling the link with the system clock keeps
  // the block in one clock domain, at the price of a link
  // clock much slower than the system clock.
  //
  // Daisy chain: the shift register is eight bits deep and
  // the serial output shows its top bit, so a bit taken in
  // reappears on the serial output eight link clocks later.

  // Synchronised pin levels; only second stages are read
  logic                   sclk_s;   // Link clock level
  logic                   cs_n_s;   // Select level, active low
  logic                   mosi_s;   // Command bit level
  logic                   clr_n_s;  // Clear level, active low
  logic [`SOSC_WIDTH-1:0] drain_s;  // Drain levels, 1 = OFF

  // Link events, each high for one system clock
  logic                   sclk_fall; // Clock fell: take a bit
  logic                   sclk_rise; // Clock rose: show a bit
  logic                   cs_fall;   // Frame opens
  logic                   cs_rise;   // Frame closes

  // Clock, select and data share one sync depth, so a clock
  // edge and the data beside it arrive in the same cycle
  sosc_sync u_sclk (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (link.sclk),
    .q       (sclk_s)
  );

  // Select idles high; its sync resets high so that no false
  // frame start follows the release of reset
  sosc_sync #(
    .RST_LEVEL (1'b1)
  ) u_cs (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (link.cs_n),
    .q       (cs_n_s)
  );

  // Command bit from the master
  sosc_sync u_mosi (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (link.mosi),
    .q       (mosi_s)
  );

  // Clear pin idles high as well; a low level clears
  sosc_sync #(
    .RST_LEVEL (1'b1)
  ) u_clr (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (clear_n),
    .q       (clr_n_s)
  );

  // Drain levels: every bit is a level of its own, so one
  // sync per bit is enough; the word is only taken at frame
  // start, long after a changed level has settled
  for (genvar i = 0; i < `SOSC_WIDTH; i++) begin : g_drain
    sosc_sync u_drain (
      .mclk    (mclk),
      .reset_n (reset_n),
      .ce      (ce),
      .d       (drain_status[i]),
      .q       (drain_s[i])
    );
  end

  // All state of the device end
  typedef struct packed {
    logic                   sclk_d;  // Last clock level
    logic                   cs_d;    // Last select level
    logic                   si_prev; // Command bit one cycle back
    logic [`SOSC_WIDTH-1:0] shreg;   // Shift register
    logic [`SOSC_WIDTH-1:0] latch;   // Command latch, 1 = OFF
    logic [`SOSC_WIDTH-1:0] drive;   // Switch states, 1 = ON
    logic                   so;      // Serial output bit
    logic                   so_oe;   // Serial driver enable
  } sosc_dev_t;
  sosc_dev_t st_reg;  // Registered state
  sosc_dev_t st_next; // Next state

  // Edge decode against the level seen one cycle earlier;
  // the history resets to the idle pins, clock low and
  // select high, so no false edge follows reset
  assign sclk_fall = st_reg.sclk_d & ~sclk_s;
  assign sclk_rise = ~st_reg.sclk_d & sclk_s;
  assign cs_fall   = st_reg.cs_d & ~cs_n_s;
  assign cs_rise   = ~st_reg.cs_d & cs_n_s;

  // Frame handling: load, shift, commit and clear
  always_comb begin
    st_next = st_reg;
    // Frozen while the enable is low
    if (ce) begin
      // History for edge decode and the held command bit
      st_next.sclk_d  = sclk_s;
      st_next.cs_d    = cs_n_s;
      st_next.si_prev = mosi_s;
      if (cs_fall) begin
        // Load drain status at frame start
        st_next.shreg = drain_s;
        st_next.so    = drain_s[`SOSC_MSB];
        st_next.so_oe = 1'b1;
      end else if (cs_rise) begin
        // Commit command, float output
        st_next.latch = st_reg.shreg;
        st_next.so_oe = 1'b0;
      end else if (!cs_n_s) begin
        // Shifting only inside a frame
        if (sclk_fall) begin
          // A master may move its bit on the very edge that
          // lowers the clock; take the bit that stood just
          // before the fall, which gives a hold margin
          st_next.shreg = {st_reg.shreg[`SOSC_MSB-1:0],
                           st_reg.si_prev};
        end else if (sclk_rise) begin
          // Rising edge presents next bit
          st_next.so = st_reg.shreg[`SOSC_MSB];
        end
      end
      // Clear wins over frame events: register empty and
      // outputs OFF; the serial driver is left alone
      if (!clr_n_s) begin
        st_next.shreg = `SOSC_ZERO8;
        st_next.latch = `SOSC_ALL_OFF;
      end
      // Inverted command: a zero bit turns its output ON
      st_next.drive = ~st_next.latch;
    end
  end

  // State register; reset leaves every output OFF and the
  // serial driver released
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.sclk_d  <= 1'b0;
      st_reg.cs_d    <= 1'b1;
      st_reg.si_prev <= 1'b0;
      st_reg.shreg   <= `SOSC_ZERO8;
      st_reg.latch   <= `SOSC_ALL_OFF;
      st_reg.drive   <= `SOSC_ZERO8;
      st_reg.so      <= 1'b0;
      st_reg.so_oe   <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register, so no
  // glitch from the decode reaches a switch or the link
  assign out_on       = st_reg.drive;
  assign link.miso_o  = st_reg.so;
  assign link.miso_oe = st_reg.so_oe;
endmodule : sosc_dev

// ### rtl/sosc_host.sv
`include "sosc_defines.svh"
// Master end: sends one 8-bit word per request
module sosc_host (
  // Clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   ce,
  // Link
  sosc_if.host                        link,
  // User request
  input  wire logic                   start,
  input  wire logic [`SOSC_WIDTH-1:0] cmd,
  output logic                        busy,
  output logic                        done,
  output logic [`SOSC_WIDTH-1:0]      status
);
  logic miso_s;
  sosc_sync u_miso (.mclk(mclk), .reset_n(reset_n), .ce(ce),
                    .d(link.miso), .q(miso_s));

  typedef struct packed {
    sosc_pkg::sosc_hst_t    state;
    logic [`SOSC_HALF_W-1:0] div;   // Half-period counter
    logic [`SOSC_CNT_W-1:0] bits;   // Bits left
    logic [`SOSC_WIDTH-1:0] tx;     // Outgoing word
    logic [`SOSC_WIDTH-1:0] rx;     // Incoming word
    logic                   sclk;
    logic                   cs_n;
    logic                   busy;
    logic                   done;
  } sosc_host_t;
  sosc_host_t st_reg;
  sosc_host_t st_next;

  // Divider-paced frame sequencer; the only link clock driver
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.done = 1'b0;
      st_next.div  = st_reg.div + 8'h01;
      unique case (st_reg.state)
        sosc_pkg::SOSC_IDLE: begin
          st_next.div = `SOSC_ZERO8;
          if (start) begin
            // Clock is low here, so select may fall
            st_next.tx    = cmd;
            st_next.cs_n  = 1'b0;
            st_next.bits  = `SOSC_BITS;
            st_next.busy  = 1'b1;
            st_next.state = sosc_pkg::SOSC_LEAD;
          end
        end
        sosc_pkg::SOSC_LEAD: begin
          if (st_reg.div == `SOSC_DIV_HALF) begin
            st_next.div   = `SOSC_ZERO8;
            st_next.state = sosc_pkg::SOSC_SHIFT;
          end
        end
        sosc_pkg::SOSC_SHIFT: begin
          if (st_reg.div == `SOSC_DIV_HALF) begin
            st_next.div  = `SOSC_ZERO8;
            st_next.sclk = ~st_reg.sclk;
            if (st_reg.sclk) begin
              // Falling edge: next MSB out, sample reply
              st_next.tx   = {st_reg.tx[`SOSC_MSB-1:0], 1'b0};
              st_next.rx   = {st_reg.rx[`SOSC_MSB-1:0],
                              miso_s};
              st_next.bits = st_reg.bits - `SOSC_ONE4;
              if (st_reg.bits == `SOSC_ONE4) begin
                st_next.state = sosc_pkg::SOSC_LAG;
              end
            end
          end
        end
        sosc_pkg::SOSC_LAG: begin
          if (st_reg.div == `SOSC_DIV_HALF) begin
            st_next.cs_n   = 1'b1;
            st_next.busy   = 1'b0;
            st_next.done   = 1'b1;
            st_next.state  = sosc_pkg::SOSC_IDLE;
          end
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.state <= sosc_pkg::SOSC_IDLE;
      st_reg.div   <= `SOSC_ZERO8;
      st_reg.bits  <= `SOSC_ZERO4;
      st_reg.tx    <= `SOSC_ZERO8;
      st_reg.rx    <= `SOSC_ZERO8;
      st_reg.sclk  <= 1'b0;
      st_reg.cs_n  <= 1'b1;
      st_reg.busy  <= 1'b0;
      st_reg.done  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.sclk = st_reg.sclk;
  assign link.cs_n = st_reg.cs_n;
  assign link.mosi = st_reg.tx[`SOSC_MSB];
  assign busy      = st_reg.busy;
  assign done      = st_reg.done;
  assign status    = st_reg.rx;
endmodule : sosc_host

// ### rtl/sosc_if.sv
interface sosc_if;
  logic sclk;      // Serial clock from master
  logic cs_n;      // Chip select, active low
  logic mosi;      // Command data to device
  logic miso_o;    // Device serial output value
  logic miso_oe;   // Device drives serial output
  wire  miso = miso_oe ? miso_o : 1'b1; // Released: idles high
  modport dev  (input sclk, input cs_n, input mosi,
                output miso_o, output miso_oe);
  modport host (output sclk, output cs_n, output mosi,
                input miso);
endinterface : sosc_if

// ### rtl/sosc_pkg.sv
`include "sosc_defines.svh"
package sosc_pkg;
  // Host sequencer states, one-hot
  typedef enum logic [3:0] {
    SOSC_IDLE  = 4'b0001,
    SOSC_LEAD  = 4'b0010,
    SOSC_SHIFT = 4'b0100,
    SOSC_LAG   = 4'b1000
  } sosc_hst_t;
endpackage : sosc_pkg

// ### rtl/sosc_sync.sv
`include "sosc_defines.svh"
// Two-stage synchroniser for an outside level
module sosc_sync #(
  // Level held in reset; match the pin's idle level
  parameter logic RST_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic ce,
  // Data
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1; // First stage, read only by s2
    logic s2; // Second stage
  } sosc_sync_t;
  sosc_sync_t st_reg;
  sosc_sync_t st_next;
  // Shift chain
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
    end
  end
  // Registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.s1 <= RST_LEVEL;
      st_reg.s2 <= RST_LEVEL;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q = st_reg.s2;
endmodule : sosc_sync
